// file: bench/holdover_regs_asserts.sv
module holdover_regs_asserts (
    // clock, reset and bus
    input wire logic       REF_CLK,
    input wire logic       ARST_N,
    input wire logic       HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic       HWRITE,
    input wire logic       HREADY,
    input wire logic       HREADYOUT,
    input wire logic       HRESP,
    // loop side
    input wire logic       LOOP1_LOCK_DETECT,
    input wire logic       INPUT_SIGNAL_LOSS,
    input wire logic       TUNE_RAIL_REACHED,
    input wire logic       REF_PULSE,
    input wire logic       FB_PULSE,
    input wire logic [1:0] SELECTED_INPUT,
    input wire logic       HOLDOVER,
    input wire logic       SWITCH_EVENT,
    input wire logic       HITLESS_SWITCH,
    input wire logic       REF_DIV_PULSE,
    input wire logic       FB_DIV_PULSE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    logic       taken;
    logic       wr_phase;
    logic       lock_prev;
    logic [1:0] sw_cause;
    logic [1:0] any_cause;
    assign taken = HSEL && HREADY && (HTRANS == holdover_regs_pkg::HTRANS_NONSEQ);
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_phase  <= 1'b0;
            lock_prev <= 1'b0;
            sw_cause  <= 2'h0;
            any_cause <= 2'h0;
        end else begin
            wr_phase  <= taken && HWRITE;
            lock_prev <= LOOP1_LOCK_DETECT;
            sw_cause  <= {sw_cause[0], TUNE_RAIL_REACHED || (lock_prev && !LOOP1_LOCK_DETECT)};
            any_cause <= {any_cause[0], TUNE_RAIL_REACHED || INPUT_SIGNAL_LOSS || (lock_prev && !LOOP1_LOCK_DETECT)};
        end
    end
    property p_okay; HRESP == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus response not okay");
    property p_read; taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT; endproperty
    a_read: assert property (p_read) else $error("read wait state wrong");
    property p_write; taken && HWRITE |=> HREADYOUT; endproperty
    a_write: assert property (p_write) else $error("write stalled");
    property p_switch; SWITCH_EVENT |-> (sw_cause != 2'h0); endproperty
    a_switch: assert property (p_switch) else $error("switch without cause");
    property p_hold; $rose(HOLDOVER) |-> (any_cause != 2'h0); endproperty
    a_hold: assert property (p_hold) else $error("holdover without cause");
    property p_sel; SELECTED_INPUT != 2'h3; endproperty
    a_sel: assert property (p_sel) else $error("selected input out of range");
    property p_refp; REF_DIV_PULSE |-> $past(REF_PULSE) || $past(REF_PULSE, 2); endproperty
    a_refp: assert property (p_refp) else $error("reference output without input");
    property p_fbp; FB_DIV_PULSE |-> $past(FB_PULSE) || $past(FB_PULSE, 2); endproperty
    a_fbp: assert property (p_fbp) else $error("feedback output without input");
    property p_hit; $changed(HITLESS_SWITCH) |-> $past(wr_phase); endproperty
    a_hit: assert property (p_hit) else $error("switch mode moved without write");
endmodule : holdover_regs_asserts

bind holdover_regs holdover_regs_asserts u_asserts (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LOOP1_LOCK_DETECT(LOOP1_LOCK_DETECT),
    .INPUT_SIGNAL_LOSS(INPUT_SIGNAL_LOSS), .TUNE_RAIL_REACHED(TUNE_RAIL_REACHED), .REF_PULSE(REF_PULSE),
    .FB_PULSE(FB_PULSE), .SELECTED_INPUT(SELECTED_INPUT), .HOLDOVER(HOLDOVER), .SWITCH_EVENT(SWITCH_EVENT),
    .HITLESS_SWITCH(HITLESS_SWITCH), .REF_DIV_PULSE(REF_DIV_PULSE), .FB_DIV_PULSE(FB_DIV_PULSE)
);

// file: bench/tb_holdover_regs.sv
module tb_holdover_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, arst_n, hsel, hwrite, lock, loss, rail, pdv, refp, fbp;
    logic        hready, hresp, sw_ev, hold, hit, rdp, fdp, irq;
    logic [1:0]  htrans, sel;
    logic [2:0]  valid;
    logic [13:0] rdiv;
    logic [31:0] haddr, hwdata, hrdata, rd, rnd, w;
    int          bad_count, compares, c_sw, c_ref, c_fb, r, f, s;
    int          n_sw = 0, n_ref = 0, n_fb = 0;
    localparam logic [7:0] rst_val [11] = '{8'h03, 8'h02, 8'h00, 8'h00, 8'h78, 8'h00, 8'h96, 8'h00, 8'h96,
                                            8'h00, 8'h78};
    localparam logic [7:0] ev_ctrl [7] = '{8'h13, 8'h01, 8'h0B, 8'h03, 8'h07, 8'h12, 8'h06};
    localparam int         ev_kind [7] = '{0, 0, 1, 1, 2, 0, 2};
    localparam logic [2:0] ev_exp  [7] = '{3'h7, 3'h0, 3'h6, 3'h0, 3'h7, 3'h1, 3'h1};

    holdover_regs dut (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .LOOP1_LOCK_DETECT(lock), .INPUT_SIGNAL_LOSS(loss), .TUNE_RAIL_REACHED(rail), .PD_CLOCK_VALID(pdv),
        .REF_PULSE(refp), .FB_PULSE(fbp), .SELECTED_INPUT(sel), .INPUT_VALID(valid), .HOLDOVER(hold),
        .SWITCH_EVENT(sw_ev), .HITLESS_SWITCH(hit), .REF_DIVIDE(rdiv), .REF_DIV_PULSE(rdp),
        .FB_DIV_PULSE(fdp), .IRQ(irq)
    );

    // ----------------------------------------------------------------
    // clock, pulse counters, helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        n_sw  <= n_sw + int'(sw_ev);
        n_ref <= n_ref + int'(rdp);
        n_fb  <= n_fb + int'(fdp);
    end
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs
    function automatic logic [31:0] wmask(input logic [9:0] idx);
        if (idx == 10'h150) return 32'h5F;
        return idx[0] ? 32'h3F : 32'hFF;
    endfunction : wmask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= holdover_regs_pkg::HTRANS_NONSEQ;
        haddr  <= {20'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= holdover_regs_pkg::HTRANS_IDLE;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic pulses(input int n, input logic [2:0] m);
        repeat (n) begin
            refp <= m[2];
            fbp  <= m[1];
            pdv  <= m[0];
            wt(1);
            refp <= 1'b0;
            fbp  <= 1'b0;
            pdv  <= 1'b0;
            wt(1);
        end
    endtask : pulses
    task automatic conclude();
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        wt(20000);
        bad_count++;
        conclude();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {arst_n, hsel, hwrite, lock, loss, rail, pdv, refp, fbp} = '0;
        {htrans, haddr, hwdata} = '0;
        {bad_count, compares} = '0;
        rnd = 32'h6FB8;
        lock = 1'b1;
        wt(4);
        arst_n <= 1'b1;
        wt(1);
        chk({18'h0, rdiv}, 32'h78);
        chk({29'h0, valid}, 32'h7);
        for (int i = 0; i < 11; i++) begin
            bus(10'h150 + 10'(i), 1'b0, 32'h0);
            chk(rd, {24'h0, rst_val[i]});
            chk({31'h0, hresp}, 32'h0);
        end
        repeat (3) for (int i = 0; i < 12; i++) begin
            w = xs();
            bus((i == 11) ? 10'h170 : 10'h150 + 10'(i), 1'b1, w);
            bus((i == 11) ? 10'h170 : 10'h150 + 10'(i), 1'b0, 32'h0);
            chk(rd, (i == 11) ? 32'h0 : w & wmask(10'h150 + 10'(i)));
        end
        for (int p = 0; p < 3; p++) begin
            r = (p == 0) ? 1 : int'(xs() % 5) + 1;
            f = int'(xs() % 6) + 1;
            bus(10'h153 + 10'(2 * p), 1'b1, 32'h0);
            bus(10'h154 + 10'(2 * p), 1'b1, 32'(r));
            bus(10'h159, 1'b1, 32'h0);
            bus(10'h15A, 1'b1, 32'(f));
            bus(10'h160, 1'b1, 32'(p));
            bus(10'h150, 1'b1, 32'h43);
            wt(2);
            chk({30'h0, sel}, 32'(p));
            chk({18'h0, rdiv}, 32'(r));
            c_ref = n_ref;
            c_fb = n_fb;
            pulses(2 * r * f, 3'h6);
            wt(2);
            chk(32'(n_ref - c_ref), 32'(2 * f));
            chk(32'(n_fb - c_fb), 32'(2 * r));
        end
        bus(10'h160, 1'b1, 32'h3);
        bus(10'h151, 1'b1, 32'h0);
        bus(10'h152, 1'b1, 32'h3);
        bus(10'h163, 1'b1, 32'h7);
        bus(10'h162, 1'b1, 32'h7);
        for (int k = 0; k < 7; k++) begin
            bus(10'h150, 1'b1, {24'h0, ev_ctrl[k]});
            c_sw = n_sw;
            s = int'(sel);
            lock <= (ev_kind[k] != 0);
            loss <= (ev_kind[k] == 1);
            rail <= (ev_kind[k] == 2);
            wt(1);
            loss <= 1'b0;
            rail <= 1'b0;
            wt(3);
            chk(32'(n_sw - c_sw), {31'h0, ev_exp[k][0]});
            chk({31'h0, hold}, {31'h0, ev_exp[k][1]});
            chk({31'h0, hit}, {31'h0, ev_ctrl[k][1]});
            if (ev_exp[k][0]) chk({30'h0, sel}, (s == 0) ? 32'h1 : 32'h0);
            lock <= 1'b1;
            pulses(2, 3'h1);
            chk({31'h0, hold}, {31'h0, ev_exp[k][1]});
            pulses(1, 3'h1);
            wt(1);
            chk({31'h0, hold}, 32'h0);
            if (ev_exp[k][1]) chk({29'h0, valid}, 32'h7);
            bus(10'h161, 1'b0, 32'h0);
            chk(rd, {29'h0, ev_exp[k]});
            chk({31'h0, irq}, {31'h0, |ev_exp[k]});
            bus(10'h163, 1'b1, 32'h0);
            wt(1);
            chk({31'h0, irq}, 32'h0);
            bus(10'h163, 1'b1, 32'h7);
            bus(10'h162, 1'b1, 32'h7);
            bus(10'h161, 1'b0, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        conclude();
    end
endmodule : tb_holdover_regs

// file: verilog/holdover_regs.sv
module holdover_regs (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // loop status inputs
    input  wire logic        LOOP1_LOCK_DETECT,
    input  wire logic        INPUT_SIGNAL_LOSS,
    input  wire logic        TUNE_RAIL_REACHED,
    input  wire logic        PD_CLOCK_VALID,
    // divider inputs
    input  wire logic        REF_PULSE,
    input  wire logic        FB_PULSE,
    // loop control outputs
    output logic      [1:0]  SELECTED_INPUT,
    output logic      [2:0]  INPUT_VALID,
    output logic             HOLDOVER,
    output logic             SWITCH_EVENT,
    output logic             HITLESS_SWITCH,
    output logic      [13:0] REF_DIVIDE,
    output logic             REF_DIV_PULSE,
    output logic             FB_DIV_PULSE,
    // interrupt
    output logic             IRQ
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } bus_state_type;

    holdover_regs_pkg::ctrl_type        ctrl;
    holdover_regs_pkg::divider_set_type divs;
    holdover_regs_pkg::bus_phase_type   phase;
    bus_state_type                      bus_state;
    logic [7:0]                         hi_byte [5];
    logic [1:0]                         policy;
    logic [2:0]                         irq_status;
    logic [2:0]                         irq_enable;
    logic                               lock_prev;
    logic [13:0]                        exit_count;
    logic [13:0]                        ref_count;
    logic [13:0]                        fb_count;
    logic [31:0]                        read_value;
    logic                               write_now;
    logic                               forced;
    logic                               lock_fall;
    logic                               rail_event;
    logic                               loss_event;
    logic                               hold_request;
    logic                               hold_leave;
    logic [1:0]                         next_input;
    logic [2:0]                         irq_event;

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    assign write_now = phase.valid && phase.write;
    assign HREADYOUT = (bus_state != BUS_READ_WAIT);
    assign HRESP     = 1'b0;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase <= '0;
        end else if (HREADY) begin
            phase.valid <= HSEL && (HTRANS == holdover_regs_pkg::HTRANS_NONSEQ
                                    || HTRANS == holdover_regs_pkg::HTRANS_SEQ);
            phase.write <= HWRITE;
            phase.index <= HADDR[11:2];
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_state <= BUS_IDLE;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (HREADY && HSEL && !HWRITE && HTRANS == holdover_regs_pkg::HTRANS_NONSEQ) begin
                        bus_state <= BUS_READ_WAIT;
                    end
                end
                BUS_READ_WAIT: begin
                    bus_state <= BUS_READ_DONE;
                end
                BUS_READ_DONE: begin
                    if (HREADY && HSEL && !HWRITE && HTRANS == holdover_regs_pkg::HTRANS_NONSEQ) begin
                        bus_state <= BUS_READ_WAIT;
                    end else begin
                        bus_state <= BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        read_value = 32'h0000_0000;
        unique case (phase.index)
            holdover_regs_pkg::IDX_SWITCH_HOLD_CTRL: read_value[7:0] = {1'b0, ctrl.force_select, 1'b0,
                ctrl.lock_loss_trigger_enable, ctrl.signal_loss_trigger_enable,
                ctrl.tune_rail_trigger_enable, ctrl.hitless, ctrl.hold_enable};
            holdover_regs_pkg::IDX_EXIT_COUNT_HI:    read_value[7:0] = hi_byte[0];
            holdover_regs_pkg::IDX_EXIT_COUNT_LO:    read_value[7:0] = divs.hold_exit_count[7:0];
            holdover_regs_pkg::IDX_REF0_DIV_HI:      read_value[7:0] = hi_byte[1];
            holdover_regs_pkg::IDX_REF0_DIV_LO:      read_value[7:0] = divs.ref0_predivider[7:0];
            holdover_regs_pkg::IDX_REF1_DIV_HI:      read_value[7:0] = hi_byte[2];
            holdover_regs_pkg::IDX_REF1_DIV_LO:      read_value[7:0] = divs.ref1_predivider[7:0];
            holdover_regs_pkg::IDX_REF2_DIV_HI:      read_value[7:0] = hi_byte[3];
            holdover_regs_pkg::IDX_REF2_DIV_LO:      read_value[7:0] = divs.ref2_predivider[7:0];
            holdover_regs_pkg::IDX_FB_DIV_HI:        read_value[7:0] = hi_byte[4];
            holdover_regs_pkg::IDX_FB_DIV_LO:        read_value[7:0] = divs.loop1_feedback_divider[7:0];
            holdover_regs_pkg::IDX_SELECT_POLICY:    read_value[1:0] = policy;
            holdover_regs_pkg::IDX_IRQ_STATUS:       read_value[2:0] = irq_status;
            holdover_regs_pkg::IDX_IRQ_ENABLE:       read_value[2:0] = irq_enable;
            holdover_regs_pkg::IDX_HOLD_STATUS:      read_value[7:0] = {1'b0, INPUT_VALID, SELECTED_INPUT,
                                                                         HITLESS_SWITCH, HOLDOVER};
            default:                                 read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_state == BUS_READ_WAIT) begin
            HRDATA <= read_value;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl   <= holdover_regs_pkg::ctrl_type'({holdover_regs_pkg::RST_CTRL[6],
                                                     holdover_regs_pkg::RST_CTRL[4:0]});
            policy <= holdover_regs_pkg::RST_POLICY;
        end else if (write_now && phase.index == holdover_regs_pkg::IDX_SWITCH_HOLD_CTRL) begin
            ctrl <= holdover_regs_pkg::ctrl_type'({HWDATA[holdover_regs_pkg::BIT_FORCE_SELECT],
                                                   HWDATA[holdover_regs_pkg::BIT_LOCK_LOSS:0]});
        end else if (write_now && phase.index == holdover_regs_pkg::IDX_SELECT_POLICY) begin
            policy <= HWDATA[1:0];
        end
    end

    // hi shadows start at the upper bits of their pair's reset value
    localparam logic [13:0] pair_rst [5] = '{holdover_regs_pkg::RST_EXIT_COUNT, holdover_regs_pkg::RST_REF0_DIV,
                                             holdover_regs_pkg::RST_REF1_DIV, holdover_regs_pkg::RST_REF2_DIV,
                                             holdover_regs_pkg::RST_FB_DIV};

    generate
        for (genvar g = 0; g < 5; g++) begin : gen_pair
            localparam logic [9:0] HI_IDX = 10'(holdover_regs_pkg::IDX_EXIT_COUNT_HI + 10'(2 * g));
            always_ff @(posedge REF_CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    hi_byte[g] <= 8'(pair_rst[g][13:8]);
                end else if (write_now && phase.index == HI_IDX) begin
                    hi_byte[g] <= HWDATA[7:0] & holdover_regs_pkg::HI_WRITE_MASK;
                end
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            divs <= {holdover_regs_pkg::RST_EXIT_COUNT, holdover_regs_pkg::RST_REF0_DIV,
                     holdover_regs_pkg::RST_REF1_DIV, holdover_regs_pkg::RST_REF2_DIV,
                     holdover_regs_pkg::RST_FB_DIV};
        end else if (write_now) begin
            unique case (phase.index)
                holdover_regs_pkg::IDX_EXIT_COUNT_LO: divs.hold_exit_count        <= {hi_byte[0][5:0], HWDATA[7:0]};
                holdover_regs_pkg::IDX_REF0_DIV_LO:   divs.ref0_predivider        <= {hi_byte[1][5:0], HWDATA[7:0]};
                holdover_regs_pkg::IDX_REF1_DIV_LO:   divs.ref1_predivider        <= {hi_byte[2][5:0], HWDATA[7:0]};
                holdover_regs_pkg::IDX_REF2_DIV_LO:   divs.ref2_predivider        <= {hi_byte[3][5:0], HWDATA[7:0]};
                holdover_regs_pkg::IDX_FB_DIV_LO:     divs.loop1_feedback_divider <= {hi_byte[4][5:0], HWDATA[7:0]};
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // switch and holdover events
    // ----------------------------------------------------------------
    assign forced       = ctrl.force_select && policy != holdover_regs_pkg::POLICY_AUTO;
    assign lock_fall    = lock_prev && !LOOP1_LOCK_DETECT && ctrl.lock_loss_trigger_enable;
    assign rail_event   = TUNE_RAIL_REACHED && ctrl.tune_rail_trigger_enable;
    assign loss_event   = INPUT_SIGNAL_LOSS && ctrl.signal_loss_trigger_enable;
    assign hold_request = ctrl.hold_enable && (lock_fall || rail_event || loss_event);
    assign hold_leave   = HOLDOVER && exit_count >= divs.hold_exit_count;

    always_comb begin
        next_input = SELECTED_INPUT;
        for (int k = 2; k >= 0; k--) begin
            if (INPUT_VALID[k] && 2'(k) != SELECTED_INPUT) begin
                next_input = 2'(k);
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= LOOP1_LOCK_DETECT;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SELECTED_INPUT <= 2'h0;
            INPUT_VALID    <= 3'h7;
            SWITCH_EVENT   <= 1'b0;
        end else begin
            SWITCH_EVENT <= 1'b0;
            if (forced) begin
                SELECTED_INPUT <= policy;
            end else if (lock_fall || rail_event) begin
                SWITCH_EVENT   <= 1'b1;
                SELECTED_INPUT <= next_input;
                if (rail_event) begin
                    INPUT_VALID[SELECTED_INPUT] <= 1'b0;
                end
            end else if (hold_leave) begin
                INPUT_VALID <= 3'h7;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOLDOVER   <= 1'b0;
            exit_count <= 14'h0000;
        end else if (!ctrl.hold_enable) begin
            HOLDOVER   <= 1'b0;
            exit_count <= 14'h0000;
        end else if (hold_request) begin
            HOLDOVER   <= 1'b1;
            exit_count <= 14'h0000;
        end else if (hold_leave) begin
            HOLDOVER   <= 1'b0;
        end else if (HOLDOVER && PD_CLOCK_VALID && LOOP1_LOCK_DETECT) begin
            exit_count <= exit_count + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    assign HITLESS_SWITCH = ctrl.hitless;

    always_comb begin
        unique case (SELECTED_INPUT)
            2'h1:    REF_DIVIDE = divs.ref1_predivider;
            2'h2:    REF_DIVIDE = divs.ref2_predivider;
            default: REF_DIVIDE = divs.ref0_predivider;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ref_count     <= 14'h0000;
            REF_DIV_PULSE <= 1'b0;
        end else begin
            REF_DIV_PULSE <= 1'b0;
            if (SWITCH_EVENT && !ctrl.hitless) begin
                ref_count <= 14'h0000;
            end else if (REF_PULSE) begin
                if (ref_count + 14'h0001 >= REF_DIVIDE) begin
                    ref_count     <= 14'h0000;
                    REF_DIV_PULSE <= 1'b1;
                end else begin
                    ref_count <= ref_count + 14'h0001;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fb_count     <= 14'h0000;
            FB_DIV_PULSE <= 1'b0;
        end else begin
            FB_DIV_PULSE <= 1'b0;
            if (FB_PULSE) begin
                if (fb_count + 14'h0001 >= divs.loop1_feedback_divider) begin
                    fb_count     <= 14'h0000;
                    FB_DIV_PULSE <= 1'b1;
                end else begin
                    fb_count <= fb_count + 14'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign irq_event = {hold_leave, hold_request && !HOLDOVER, SWITCH_EVENT};

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
        end else begin
            if (write_now && phase.index == holdover_regs_pkg::IDX_IRQ_ENABLE) begin
                irq_enable <= HWDATA[2:0];
            end
            if (write_now && phase.index == holdover_regs_pkg::IDX_IRQ_CLEAR) begin
                irq_status <= (irq_status & ~HWDATA[2:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
        end
    end

    assign IRQ = |(irq_status & irq_enable);

endmodule : holdover_regs

// file: verilog/holdover_regs_pkg.sv
package holdover_regs_pkg;

    // ----------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_SWITCH_HOLD_CTRL = 10'h150;
    localparam logic [9:0] IDX_EXIT_COUNT_HI    = 10'h151;
    localparam logic [9:0] IDX_EXIT_COUNT_LO    = 10'h152;
    localparam logic [9:0] IDX_REF0_DIV_HI      = 10'h153;
    localparam logic [9:0] IDX_REF0_DIV_LO      = 10'h154;
    localparam logic [9:0] IDX_REF1_DIV_HI      = 10'h155;
    localparam logic [9:0] IDX_REF1_DIV_LO      = 10'h156;
    localparam logic [9:0] IDX_REF2_DIV_HI      = 10'h157;
    localparam logic [9:0] IDX_REF2_DIV_LO      = 10'h158;
    localparam logic [9:0] IDX_FB_DIV_HI        = 10'h159;
    localparam logic [9:0] IDX_FB_DIV_LO        = 10'h15A;
    localparam logic [9:0] IDX_SELECT_POLICY    = 10'h160;
    localparam logic [9:0] IDX_IRQ_STATUS       = 10'h161;
    localparam logic [9:0] IDX_IRQ_CLEAR        = 10'h162;
    localparam logic [9:0] IDX_IRQ_ENABLE       = 10'h163;
    localparam logic [9:0] IDX_HOLD_STATUS      = 10'h164;

    // ----------------------------------------------------------------
    // field positions of the switch and holdover control register
    // ----------------------------------------------------------------
    localparam int BIT_FORCE_SELECT = 6;
    localparam int BIT_LOCK_LOSS    = 4;
    localparam int BIT_SIGNAL_LOSS  = 3;
    localparam int BIT_TUNE_RAIL    = 2;
    localparam int BIT_HITLESS      = 1;
    localparam int BIT_HOLD_ENABLE  = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h5F;
    localparam logic [7:0] HI_WRITE_MASK   = 8'h3F;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL       = 8'h03;
    localparam logic [13:0] RST_EXIT_COUNT = 14'h0200;
    localparam logic [13:0] RST_REF0_DIV   = 14'h0078;
    localparam logic [13:0] RST_REF1_DIV   = 14'h0096;
    localparam logic [13:0] RST_REF2_DIV   = 14'h0096;
    localparam logic [13:0] RST_FB_DIV     = 14'h0078;
    localparam logic [1:0]  RST_POLICY     = 2'h0;
    localparam logic [1:0]  POLICY_AUTO    = 2'h3;

    // ----------------------------------------------------------------
    // interrupt event bits
    // ----------------------------------------------------------------
    localparam int IRQ_SWITCH     = 0;
    localparam int IRQ_HOLD_ENTER = 1;
    localparam int IRQ_HOLD_EXIT  = 2;
    localparam int IRQ_BITS       = 3;

    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'h0,
        HTRANS_BUSY   = 2'h1,
        HTRANS_NONSEQ = 2'h2,
        HTRANS_SEQ    = 2'h3
    } htrans_type;

    typedef struct packed {
        logic       force_select;
        logic       lock_loss_trigger_enable;
        logic       signal_loss_trigger_enable;
        logic       tune_rail_trigger_enable;
        logic       hitless;
        logic       hold_enable;
    } ctrl_type;

    typedef struct packed {
        logic [13:0] hold_exit_count;
        logic [13:0] ref0_predivider;
        logic [13:0] ref1_predivider;
        logic [13:0] ref2_predivider;
        logic [13:0] loop1_feedback_divider;
    } divider_set_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [9:0] index;
    } bus_phase_type;

endpackage : holdover_regs_pkg
